// ---- rail_mon_pkg.sv ----
// Purpose: Shared constants for the rail monitor filter and fault detect
// Assumes: 100 MHz pclk, APB slave with 32-bit words
// Notes: Contract list below, one line per behaviour
// Contract
// - Current averaged over last 4 samples
// - One rail current per slot, rotating
// - Undercurrent checked only after power good
// - No voltage monitor: current after turn-on delay
// - Current from milliohm gain plus offset
// - One rail temperature per 100 ms slot
// - Temperature averaged over last 16 samples
// - Temperature monitoring starts right after reset
// - Temperature from degree-per-volt gain plus offset
// - Host temperature held until rewritten
// - Host write stops temperature pin sampling
// - No temperature pin: internal sensor used
// - Host temperature feeds limits and peak
// - Window exit sets status, alert low
// - Per-input glitch filter, 400 us steps
// - Results stepped through in turn, compared
// - Turn-on timeout fault without power good
// - Undervoltage only after power good reached
// - Overvoltage flagged at any time
// - Turn-off warning above 12.5 percent nominal
// - Each rail voltage sampled every 400 us
// - Warnings never request fault logging
package rail_mon_pkg;
    localparam int NR          = 10;      // Rails
    localparam int CLK_MHZ     = 100;     // pclk rate
    localparam int V_PERIOD_US = 400;     // Voltage sweep period
    localparam int V_SLOT_CYC  = V_PERIOD_US * CLK_MHZ / NR;
    localparam int I_SLOT_US   = 200;     // One current slot
    localparam int I_SLOT_CYC  = I_SLOT_US * CLK_MHZ;
    localparam int T_SLOT_MS   = 100;     // One temperature slot
    localparam int T_SLOT_CYC  = T_SLOT_MS * 1000 * CLK_MHZ;
    localparam int MS_CYC      = 1000 * CLK_MHZ;
    localparam int TOFF_SHIFT  = 3;       // Nominal / 8 = 12.5 %
    localparam int I_SCALE     = 625000;  // Code to mV times 1000
    localparam int I_SHIFT     = 10;
    localparam int T_MUL       = 5;       // Code to volts, 2.5/4096
    localparam int T_SHIFT     = 13;
    localparam int HI          = 16;      // Upper field position
    localparam int C_GLIM      = 16;      // Glitch length field
    localparam int C_GLEN      = 24;      // Glitch enable bit
    localparam int C_HASV      = 25;      // Voltage monitor present
    localparam int C_HAST      = 26;      // Temperature pin present
    localparam logic [7:0] A_SEL   = 8'h00;
    localparam logic [7:0] A_HTEMP = 8'h04;
    localparam logic [7:0] A_READ  = 8'h08;
    localparam logic [7:0] A_STAT  = 8'h0c;
    localparam logic [7:0] A_CFG   = 8'h10;
    localparam int NCFG = 10;             // Config words per rail
    localparam int W_VUV = 0, W_VOV = 1, W_VPG = 2, W_TIM = 3, W_MISC = 4;
    localparam int W_ILIM = 5, W_IUC = 6, W_ICAL = 7, W_TCAL = 8;
    localparam int W_TLIM = 9;
    localparam logic [31:0] CFG_RST [NCFG] = '{32'h0000_0000,
        32'h0fff_0fff, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'hffff_ffff, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000,
        32'hffff_ffff};
    localparam logic [31:0] CFG_MSK [NCFG] = '{32'h0fff_0fff,
        32'h0fff_0fff, 32'h0fff_0fff, 32'h0fff_0fff, 32'h07ff_0fff,
        32'hffff_ffff, 32'h0000_ffff, 32'hffff_ffff, 32'hffff_ffff,
        32'hffff_ffff};
    localparam int S_TON = 0, S_UVW = 1, S_UVF = 2, S_OVW = 3, S_OVF = 4;
    localparam int S_TOFF = 5, S_OCW = 6, S_OCF = 7, S_UCF = 8;
    localparam int S_OTW = 9, S_OTF = 10, NST = 11;
    localparam logic [10:0] FAULT_MASK = 11'h595;
    typedef enum logic [1:0] {K_VOLT, K_CUR, K_TEMP} kind_t;
endpackage

// ---- rail_monitor_filter_and_fault_detect.sv ----
// Purpose: Rail voltage, current and temperature filtering and limits
// Assumes: ADC answers each adc_req with one adc_valid pulse
// Notes: Per-rail settings are reached through the rail select window
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module rail_monitor_filter_and_fault_detect #(
    parameter int I_SLOT_CYC = rail_mon_pkg::I_SLOT_CYC,
    parameter int T_SLOT_CYC = rail_mon_pkg::T_SLOT_CYC,
    parameter int MS_CYC     = rail_mon_pkg::MS_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             adc_req,
    output logic      [3:0]  adc_rail,
    output logic      [1:0]  adc_kind,
    input  wire logic        adc_valid,
    input  wire logic [11:0] adc_data,
    input  wire logic [15:0] int_temp,
    input  wire logic [9:0]  rail_on,
    output logic             alert_out_n,
    output logic             fault_log_req
);
    localparam int NR = rail_mon_pkg::NR;
    localparam int NST = rail_mon_pkg::NST;

    // Next rail in the rotation
    function automatic logic [3:0] nxt(input logic [3:0] r);
        nxt = (r == 4'(NR - 1)) ? 4'h0 : 4'(r + 4'h1);
    endfunction

    logic [31:0] cfg [NR][rail_mon_pkg::NCFG]; // Rail settings
    logic [3:0]  sel_reg;            // Rail select window
    logic [NST-1:0] stat [NR];       // Sticky status
    logic [NST-1:0] sset [NR];       // Status set this cycle
    logic [15:0] ibuf [NR][4];       // Current history
    logic [1:0]  iptr [NR];
    logic [17:0] isum [NR];
    logic [15:0] tbuf [NR][16];      // Temperature history
    logic [3:0]  tptr [NR];
    logic [19:0] tsum [NR];
    logic [15:0] htemp [NR];         // Host temperature
    logic [15:0] peak [NR];          // Peak temperature
    logic [11:0] vlast [NR];         // Last voltage
    logic [7:0]  gcnt [NR][4];       // Glitch persistence counts
    logic [12:0] tmr [NR];           // Ms since last on or off
    logic [NR-1:0] hval, pg_ok, on_q;
    logic [31:0] vcnt, icnt, tcnt, mcnt;
    logic [3:0]  vrail, irail, trail, tq_rail;
    logic        pend_v, pend_i, pend_t, busy;

    // Bus decode; pready is registered, giving one wait state
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire [7:0] coff = 8'(paddr - rail_mon_pkg::A_CFG);
    wire [3:0] cidx = coff[5:2];
    wire cfg_hit = paddr[1:0] == 2'b00 && paddr >= rail_mon_pkg::A_CFG
        && cidx < 4'(rail_mon_pkg::NCFG) && coff[7:6] == 2'b00;
    wire hit = cfg_hit || paddr == rail_mon_pkg::A_SEL
        || paddr == rail_mon_pkg::A_HTEMP || paddr == rail_mon_pkg::A_READ
        || paddr == rail_mon_pkg::A_STAT;
    wire h_ev = wr && paddr == rail_mon_pkg::A_HTEMP;
    wire s_clr = wr && paddr == rail_mon_pkg::A_STAT;

    // Slot timers
    wire v_tick = vcnt == 32'(rail_mon_pkg::V_SLOT_CYC - 1);
    wire i_tick = icnt == 32'(I_SLOT_CYC - 1);
    wire t_tick = tcnt == 32'(T_SLOT_CYC - 1);
    wire ms_tick = mcnt == 32'(MS_CYC - 1);
    wire iss_v = !busy && pend_v;
    wire iss_i = !busy && !pend_v && pend_i;
    // A host write retires a queued pin conversion for that rail
    wire t_drop = hval[tq_rail] || (h_ev && sel_reg == tq_rail);
    wire iss_t = !busy && !pend_v && !pend_i && pend_t && !t_drop;

    // Result decode against the outstanding request
    wire [3:0] ar = adc_rail;
    wire got = adc_valid && busy;
    wire v_ev = got && adc_kind == rail_mon_pkg::K_VOLT;
    wire i_ev = got && adc_kind == rail_mon_pkg::K_CUR;
    wire t_adc = got && adc_kind == rail_mon_pkg::K_TEMP && !hval[ar];
    wire t_has = cfg[trail][rail_mon_pkg::W_MISC][rail_mon_pkg::C_HAST];
    wire t_int = t_tick && !t_has && !hval[trail] && !t_adc;
    wire t_ev = t_adc || t_int;

    // Voltage comparisons
    wire [31:0] cuv = cfg[ar][rail_mon_pkg::W_VUV];
    wire [31:0] cov = cfg[ar][rail_mon_pkg::W_VOV];
    wire [31:0] cmi = cfg[ar][rail_mon_pkg::W_MISC];
    wire [7:0] glim = cmi[rail_mon_pkg::C_GLIM +: 8];
    wire [3:0] vcond = {adc_data > cov[rail_mon_pkg::HI +: 12],
        adc_data > cov[11:0],
        pg_ok[ar] && adc_data < cuv[rail_mon_pkg::HI +: 12],
        pg_ok[ar] && adc_data < cuv[11:0]};
    logic [7:0] gnew [4];
    logic [3:0] vpass;
    genvar k;
    generate
        for (k = 0; k < 4; k++)
        begin : g_glitch
            // Saturating run length of one violation kind
            assign gnew[k] = !vcond[k] ? 8'h00 :
                (gcnt[ar][k] == 8'hff ? 8'hff : 8'(gcnt[ar][k] + 8'h01));
            // Filtered flag needs the full run; 400 us per sample
            assign vpass[k] = vcond[k] && (!cmi[rail_mon_pkg::C_GLEN]
                || gnew[k] >= glim);
        end
    endgenerate
    wire [NST-1:0] vset = NST'({vpass[3], vpass[2], vpass[1], vpass[0],
        1'b0});

    // Current conversion and 4-sample average
    wire [31:0] ical = cfg[ar][rail_mon_pkg::W_ICAL];
    wire [31:0] iraw = (32'(adc_data) * 32'(rail_mon_pkg::I_SCALE))
        >> rail_mon_pkg::I_SHIFT;
    wire [31:0] idiv = ical[15:0] == 16'h0000 ? 32'h0 :
        iraw / 32'(ical[15:0]);
    wire [15:0] ival = 16'(ical[rail_mon_pkg::HI +: 16] + idiv[15:0]);
    wire [17:0] inew_sum = 18'(isum[ar] - 18'(ibuf[ar][iptr[ar]])
        + 18'(ival));
    wire [15:0] iavg = inew_sum[17:2];
    wire [31:0] ctim = cfg[ar][rail_mon_pkg::W_TIM];
    wire i_live = cmi[rail_mon_pkg::C_HASV] ? pg_ok[ar] :
        (on_q[ar] && tmr[ar] >= 13'(ctim[11:0]));
    wire [31:0] cil = cfg[ar][rail_mon_pkg::W_ILIM];
    wire [15:0] ucl = cfg[ar][rail_mon_pkg::W_IUC][15:0];
    wire [NST-1:0] iset = i_live ? NST'({iavg < ucl,
        iavg > cil[rail_mon_pkg::HI +: 16], iavg > cil[15:0], 6'h00})
        : '0;

    // Temperature conversion and 16-sample average
    wire [31:0] tcal = cfg[ar][rail_mon_pkg::W_TCAL];
    wire [31:0] traw = (32'(adc_data) * 32'(tcal[15:0])
        * 32'(rail_mon_pkg::T_MUL)) >> rail_mon_pkg::T_SHIFT;
    wire [15:0] tval = 16'(tcal[rail_mon_pkg::HI +: 16] + traw[15:0]);
    wire [3:0] ts_r = t_adc ? ar : trail;
    wire [15:0] ts_v = t_adc ? tval : int_temp;
    wire [19:0] tnew_sum = 20'(tsum[ts_r] - 20'(tbuf[ts_r][tptr[ts_r]])
        + 20'(ts_v));
    wire tchk = h_ev || t_ev;
    wire [3:0] tc_r = h_ev ? sel_reg : ts_r;
    wire [15:0] tc_v = h_ev ? pwdata[15:0] : tnew_sum[19:4];
    wire [31:0] ctl = cfg[tc_r][rail_mon_pkg::W_TLIM];
    wire [NST-1:0] tset = NST'({tc_v > ctl[rail_mon_pkg::HI +: 16],
        tc_v > ctl[15:0], 9'h000});

    // Gather status sets per rail, including timer based flags
    always_comb
    begin
        for (int r = 0; r < NR; r++)
        begin
            sset[r] = '0;
            if (v_ev && ar == 4'(r))
                sset[r] = sset[r] | vset;
            if (i_ev && ar == 4'(r))
                sset[r] = sset[r] | iset;
            if (tchk && tc_r == 4'(r))
                sset[r] = sset[r] | tset;
            // Turn-on timeout measured after the turn-on delay
            if (on_q[r] && !pg_ok[r]
                && cfg[r][rail_mon_pkg::W_TIM][27:16] != 12'h000
                && tmr[r] >= 13'(cfg[r][rail_mon_pkg::W_TIM][11:0])
                + 13'(cfg[r][rail_mon_pkg::W_TIM][27:16]))
                sset[r][rail_mon_pkg::S_TON] = 1'b1;
            // Still above an eighth of nominal after the off window
            if (!on_q[r] && cfg[r][rail_mon_pkg::W_MISC][11:0] != 12'h000
                && tmr[r] >= 13'(cfg[r][rail_mon_pkg::W_MISC][11:0])
                && vlast[r] > (cfg[r][rail_mon_pkg::W_VPG][27:16]
                >> rail_mon_pkg::TOFF_SHIFT))
                sset[r][rail_mon_pkg::S_TOFF] = 1'b1;
        end
    end

    logic [NST-1:0] snext [NR];
    logic any_next, flog_next;
    // Set wins over a simultaneous write-one-to-clear
    always_comb
    begin
        any_next = 1'b0;
        flog_next = 1'b0;
        for (int r = 0; r < NR; r++)
        begin
            snext[r] = (stat[r] & ~((s_clr && sel_reg == 4'(r)) ?
                pwdata[NST-1:0] : '0)) | sset[r];
            any_next = any_next | (|snext[r]);
            flog_next = flog_next
                | (|(sset[r] & ~stat[r] & rail_mon_pkg::FAULT_MASK));
        end
    end

    // Read data selection
    logic [31:0] rdata;
    always_comb
    begin
        rdata = 32'h0;
        if (cfg_hit)
            rdata = cfg[sel_reg][cidx];
        else if (paddr == rail_mon_pkg::A_SEL)
            rdata = 32'(sel_reg);
        else if (paddr == rail_mon_pkg::A_HTEMP)
            rdata = {peak[sel_reg], hval[sel_reg] ? htemp[sel_reg]
                : tsum[sel_reg][19:4]};
        else if (paddr == rail_mon_pkg::A_READ)
            rdata = {4'h0, vlast[sel_reg], isum[sel_reg][17:2]};
        else if (paddr == rail_mon_pkg::A_STAT)
            rdata = 32'(stat[sel_reg]);
    end

    // APB slave and setting storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            sel_reg <= 4'h0;
            for (int r = 0; r < NR; r++)
                for (int w = 0; w < rail_mon_pkg::NCFG; w++)
                    cfg[r][w] <= rail_mon_pkg::CFG_RST[w];
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            prdata <= (psel && penable && !pready) ? rdata : 32'h0;
            if (wr && paddr == rail_mon_pkg::A_SEL)
                sel_reg <= pwdata[3:0] < 4'(NR) ? pwdata[3:0] : sel_reg;
            if (wr && cfg_hit)
                cfg[sel_reg][cidx] <= pwdata & rail_mon_pkg::CFG_MSK[cidx];
        end
    end

    // Slot timers and ADC request scheduler, running from reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {vcnt, icnt, tcnt, mcnt} <= '0;
            {vrail, irail, trail, tq_rail} <= '0;
            {pend_v, pend_i, pend_t, busy, adc_req} <= '0;
            adc_rail <= 4'h0;
            adc_kind <= rail_mon_pkg::K_VOLT;
        end
        else
        begin
            vcnt <= v_tick ? 32'h0 : vcnt + 32'h1;
            icnt <= i_tick ? 32'h0 : icnt + 32'h1;
            tcnt <= t_tick ? 32'h0 : tcnt + 32'h1;
            mcnt <= ms_tick ? 32'h0 : mcnt + 32'h1;
            pend_v <= v_tick || (pend_v && !iss_v);
            pend_i <= i_tick || (pend_i && !iss_i);
            // Pin sampling stops once the host owns the value
            pend_t <= (t_tick && t_has && !hval[trail])
                || (pend_t && !iss_t && !t_drop);
            if (t_tick)
            begin
                trail <= nxt(trail);
                tq_rail <= trail;
            end
            adc_req <= iss_v || iss_i || iss_t;
            if (iss_v || iss_i || iss_t)
                busy <= 1'b1;
            else if (adc_valid)
                busy <= 1'b0;
            if (iss_v)
            begin
                adc_rail <= vrail;
                adc_kind <= rail_mon_pkg::K_VOLT;
                vrail <= nxt(vrail);
            end
            else if (iss_i)
            begin
                adc_rail <= irail;
                adc_kind <= rail_mon_pkg::K_CUR;
                irail <= nxt(irail);
            end
            else if (iss_t)
            begin
                adc_rail <= tq_rail;
                adc_kind <= rail_mon_pkg::K_TEMP;
            end
        end
    end

    // Rail timers, power good, status and alert
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {hval, pg_ok, on_q} <= '0;
            alert_out_n <= 1'b1;
            fault_log_req <= 1'b0;
            for (int r = 0; r < NR; r++)
            begin
                stat[r] <= '0;
                tmr[r] <= 13'h0;
                vlast[r] <= 12'h0;
                htemp[r] <= 16'h0;
                peak[r] <= 16'h0;
                gcnt[r] <= '{default: 8'h00};
            end
        end
        else
        begin
            alert_out_n <= !any_next;
            fault_log_req <= flog_next;
            for (int r = 0; r < NR; r++)
            begin
                stat[r] <= snext[r];
                on_q[r] <= rail_on[r];
                if (rail_on[r] != on_q[r])
                    tmr[r] <= 13'h0;
                else if (ms_tick && tmr[r] != 13'h1fff)
                    tmr[r] <= 13'(tmr[r] + 13'h1);
                if (!rail_on[r])
                    pg_ok[r] <= 1'b0;
                else if (v_ev && ar == 4'(r) && adc_data
                    >= cfg[r][rail_mon_pkg::W_VPG][11:0])
                    pg_ok[r] <= 1'b1;
            end
            if (v_ev)
            begin
                vlast[ar] <= adc_data;
                for (int c = 0; c < 4; c++)
                    gcnt[ar][c] <= gnew[c];
            end
            if (h_ev)
            begin
                hval[sel_reg] <= 1'b1;
                htemp[sel_reg] <= pwdata[15:0];
            end
            if (tchk && (h_ev || !hval[tc_r]) && tc_v > peak[tc_r])
                peak[tc_r] <= tc_v;
        end
    end

    // Sliding average histories
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int r = 0; r < NR; r++)
            begin
                ibuf[r] <= '{default: 16'h0};
                tbuf[r] <= '{default: 16'h0};
                {iptr[r], tptr[r], isum[r], tsum[r]} <= '0;
            end
        end
        else
        begin
            if (i_ev)
            begin
                ibuf[ar][iptr[ar]] <= ival;
                iptr[ar] <= 2'(iptr[ar] + 2'h1);
                isum[ar] <= inew_sum;
            end
            if (t_ev)
            begin
                tbuf[ts_r][tptr[ts_r]] <= ts_v;
                tptr[ts_r] <= 4'(tptr[ts_r] + 4'h1);
                tsum[ts_r] <= tnew_sum;
            end
        end
    end

    // Checks
    alert_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        any_next |=> !alert_out_n) else $error("alert not low");
    ov_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        v_ev && vpass[3] |=> stat[$past(ar)][rail_mon_pkg::S_OVF])
        else $error("overvoltage not flagged");
    uv_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        v_ev && vset[rail_mon_pkg::S_UVF] |-> pg_ok[ar])
        else $error("undervoltage before power good");
    warn_nolog_a: assert property (@(posedge pclk) disable iff (!presetn)
        !flog_next |=> !fault_log_req)
        else $error("log without fault");
    host_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        adc_req && adc_kind == rail_mon_pkg::K_TEMP |-> !hval[adc_rail])
        else $error("pin sampled after host write");
    v_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        iss_v |=> vrail == nxt($past(vrail)))
        else $error("voltage rail not stepped");
    v_space_a: assert property (@(posedge pclk) disable iff (!presetn)
        v_tick |=> !v_tick [*8])
        else $error("voltage slot too short");
    uc_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        i_ev && iset[rail_mon_pkg::S_UCF] |-> on_q[ar]
        && (pg_ok[ar] || !cmi[rail_mon_pkg::C_HASV]))
        else $error("undercurrent before live");
endmodule
`default_nettype wire

// ---- rail_adc_model.sv ----
// Purpose: Behavioural ADC and sensor front end facing the monitor block
// Assumes: One request outstanding, answered by one adc_valid pulse
// Notes: Latency alternates between prompt and slow answers
`timescale 1ns/10ps
`default_nettype none
module rail_adc_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        adc_req,
    input  wire logic [1:0]  adc_kind,
    input  wire logic [11:0] volt_code,
    input  wire logic [11:0] other_code,
    output logic             adc_valid,
    output logic      [11:0] adc_data
);
    logic [3:0] wait_cnt;  // Cycles left before the answer
    logic       busy;      // Conversion in flight
    logic       slow;      // Alternate latency each conversion

    // Conversion timing; data not valid shows inverse so no stale match
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            busy      <= 1'b0;
            slow      <= 1'b0;
            wait_cnt  <= 4'h0;
            adc_valid <= 1'b0;
            adc_data  <= 12'h000;
        end
        else
        begin
            adc_valid <= 1'b0;
            if (adc_valid)
                adc_data <= ~adc_data;
            if (adc_req && !busy)
            begin
                busy     <= 1'b1;
                slow     <= !slow;
                wait_cnt <= slow ? 4'h9 : 4'h2;
            end
            else if (busy && wait_cnt != 4'h0)
                wait_cnt <= wait_cnt - 4'h1;
            else if (busy)
            begin
                // Voltage kind returns the rail code, others a fixed code
                busy      <= 1'b0;
                adc_valid <= 1'b1;
                adc_data  <= (adc_kind == 2'd0) ? volt_code : other_code;
            end
        end
endmodule
`default_nettype wire

// ---- rail_monitor_filter_and_fault_detect_bench.sv ----
// Purpose: Self-checking bench for the rail monitor block
// Assumes: Short slot parameters, ADC partner model
// Notes: One rail's voltage samples are 40000 cycles apart
`timescale 1ns/10ps
`default_nettype none
module rail_monitor_filter_and_fault_detect_bench;
    logic        pclk = 1'b0;            // 100 MHz clock
    logic        presetn = 1'b0;         // Reset, active low
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;          // APB byte address
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, adc_req, adc_valid, alert_out_n;
    logic        fault_log_req, se;
    logic [3:0]  adc_rail;
    logic [1:0]  adc_kind;
    logic [11:0] adc_data, volt_code = 12'h050;
    logic [9:0]  rail_on = 10'h000;      // Rail enables
    int          err_count = 0, checks_done = 0, log_count = 0;

    always #5 pclk = ~pclk;  // Half period 5 ns

    rail_monitor_filter_and_fault_detect #(.I_SLOT_CYC(40),
        .T_SLOT_CYC(200), .MS_CYC(20)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_req(adc_req),
        .adc_rail(adc_rail), .adc_kind(adc_kind), .adc_valid(adc_valid),
        .adc_data(adc_data), .int_temp(16'h0019), .rail_on(rail_on),
        .alert_out_n(alert_out_n), .fault_log_req(fault_log_req));

    rail_adc_model adc (.pclk(pclk), .presetn(presetn), .adc_req(adc_req),
        .adc_kind(adc_kind), .volt_code(volt_code), .other_code(12'h100),
        .adc_valid(adc_valid), .adc_data(adc_data));

    // Count fault log pulses; a pulse stands one cycle
    always @(posedge pclk)
        if (fault_log_req === 1'b1)
            log_count++;

    task automatic print_verdict();
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        se = pslverr;
        if (n >= 100)
        begin
            err_count++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Bounded wait for the alert level
    task automatic wait_alert(input logic lvl);
        int n;
        for (n = 0; n < 45000 && alert_out_n !== lvl; n++)
            @(posedge pclk);
        if (n >= 45000)
        begin
            err_count++;
            print_verdict();
        end
    endtask

    // Config reset values and an unmapped address
    task automatic test_reset_map();
        for (int k = 0; k < 10; k++)
        begin
            apb(1'b0, rail_mon_pkg::A_CFG + 8'(4 * k), 32'h0000_0000);
            check("config reset", rd, rail_mon_pkg::CFG_RST[k]);
        end
        apb(1'b0, 8'hfc, 32'h0000_0000);
        check("unmapped err", {31'h0, se}, 32'h1);
        check("unmapped data", rd, 32'h0000_0000);
    endtask

    // Warning sets status and alert without a log request, then clears
    task automatic test_ov_warn();
        int n0;
        apb(1'b1, rail_mon_pkg::A_SEL, 32'h0000_0000);
        apb(1'b1, rail_mon_pkg::A_CFG + 8'h04, 32'h0fff_0100);
        volt_code <= 12'h200;
        n0 = log_count;
        wait_alert(1'b0);
        apb(1'b0, rail_mon_pkg::A_STAT, 32'h0000_0000);
        check("ov warn stat", rd, 32'h0000_0008);
        check("warn log", 32'(log_count - n0), 32'h0);
        volt_code <= 12'h050;
        apb(1'b1, rail_mon_pkg::A_STAT, 32'h0000_0008);
        repeat (2) @(posedge pclk);
        check("alert cleared", {31'h0, alert_out_n}, 32'h1);
    endtask

    // Fault sets its own bit and requests one log entry
    task automatic test_ov_fault();
        int n0;
        apb(1'b1, rail_mon_pkg::A_CFG + 8'h04, 32'h0200_0fff);
        volt_code <= 12'h300;
        n0 = log_count;
        wait_alert(1'b0);
        apb(1'b0, rail_mon_pkg::A_STAT, 32'h0000_0000);
        check("ov fault stat", rd, 32'h0000_0010);
        check("fault log", 32'(log_count - n0), 32'h1);
    endtask

    // Host temperature is held across slots and drives limits and peak
    task automatic test_host_temp();
        apb(1'b1, rail_mon_pkg::A_SEL, 32'h0000_0001);
        apb(1'b1, rail_mon_pkg::A_CFG + 8'h24, 32'hffff_0040);
        apb(1'b1, rail_mon_pkg::A_HTEMP, 32'h0000_0050);
        apb(1'b0, rail_mon_pkg::A_HTEMP, 32'h0000_0000);
        check("host temp", rd, 32'h0050_0050);
        repeat (2500) @(posedge pclk);
        apb(1'b0, rail_mon_pkg::A_HTEMP, 32'h0000_0000);
        check("temp held", rd, 32'h0050_0050);
        apb(1'b0, rail_mon_pkg::A_STAT, 32'h0000_0000);
        check("ot warn stat", rd, 32'h0000_0200);
    endtask

    // Enabled rail that never reaches power good trips the timeout
    task automatic test_ton();
        int n0;
        apb(1'b1, rail_mon_pkg::A_SEL, 32'h0000_0002);
        apb(1'b1, rail_mon_pkg::A_CFG + 8'h08, 32'h0000_0fff);
        apb(1'b1, rail_mon_pkg::A_CFG + 8'h0c, 32'h0002_0001);
        n0 = log_count;
        rail_on <= 10'h004;
        repeat (120) @(posedge pclk);
        apb(1'b0, rail_mon_pkg::A_STAT, 32'h0000_0000);
        check("ton fault stat", rd, 32'h0000_0001);
        check("ton log", 32'(log_count - n0), 32'h1);
    endtask

    // Main sequence: reset for six cycles, then each scenario
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("alert idle", {31'h0, alert_out_n}, 32'h1);
        test_reset_map();
        test_ov_warn();
        test_ov_fault();
        test_host_temp();
        test_ton();
        print_verdict();
    end
endmodule
`default_nettype wire
